/* File: inc/rfre_pkg.sv */
// Package: fault reason codes, register map and request carriers
// What this block does
// - Reserved bit set in a readable or writable page entry gives code Ch.
// - Translation type in a present context entry forbidding request gives Dh.
// - Reserved field set in a remappable interrupt gives code 20h.
// - Interrupt index above the configured table size limit gives 21h.
// - Selected interrupt map entry not present gives code 22h.
// - Error fetching from the interrupt table base gives code 23h.
// - Present map entry with nonzero reserved bits gives code 24h.
// - Compat interrupt with extended mode on or compat disallowed gives 25h.
// - Failed source identifier check on a present entry gives code 26h.
// - Root entry not present for a DMA request gives code 1h.
`default_nettype none
package rfre_pkg;
  // ==========================================================
  // Reason codes
  localparam logic [7:0] RFRE_CODE_NONE = 8'h00;
  localparam logic [7:0] RFRE_CODE_ROOT_ABSENT = 8'h01;
  localparam logic [7:0] RFRE_CODE_PTE_RSVD = 8'h0C;
  localparam logic [7:0] RFRE_CODE_TT_BLOCK = 8'h0D;
  localparam logic [7:0] RFRE_CODE_IRQ_RSVD = 8'h20;
  localparam logic [7:0] RFRE_CODE_IDX_RANGE = 8'h21;
  localparam logic [7:0] RFRE_CODE_ENTRY_ABSENT = 8'h22;
  localparam logic [7:0] RFRE_CODE_TABLE_ERR = 8'h23;
  localparam logic [7:0] RFRE_CODE_ENTRY_RSVD = 8'h24;
  localparam logic [7:0] RFRE_CODE_COMPAT_BLOCK = 8'h25;
  localparam logic [7:0] RFRE_CODE_SRC_FAIL = 8'h26;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] RFRE_OFS_CTRL = 8'h00;
  localparam logic [7:0] RFRE_OFS_TBASE = 8'h04;
  localparam logic [7:0] RFRE_OFS_STATUS = 8'h08;
  localparam logic [7:0] RFRE_OFS_MASK = 8'h0C;
  localparam logic [7:0] RFRE_OFS_LAST = 8'h10;
  localparam logic [7:0] RFRE_OFS_COUNT = 8'h14;
  // ==========================================================
  // Field positions
  localparam int RFRE_CTRL_COMPAT_FORMAT_ALLOWED_STATUS_BIT = 0;
  localparam int RFRE_TBASE_SIZE_LSB = 0;
  localparam int RFRE_TBASE_EXTENDED_IRQ_MODE_ENABLE_BIT = 11;
  localparam int RFRE_TBASE_ADDR_LSB = 12;
  localparam int RFRE_ST_DMA_BIT = 0;
  localparam int RFRE_ST_IRQ_BIT = 1;
  localparam int RFRE_LAST_DMA_LSB = 0;
  localparam int RFRE_LAST_IRQ_LSB = 8;
  // ==========================================================
  // Reset values
  localparam logic RFRE_RST_COMPAT_FORMAT_ALLOWED_STATUS = 1'b0;
  localparam logic RFRE_RST_EXTENDED_IRQ_MODE_ENABLE = 1'b0;
  localparam logic [3:0] RFRE_RST_SIZE = 4'h0;
  localparam logic [19:0] RFRE_RST_ADDR = 20'h0_0000;
  localparam logic [1:0] RFRE_RST_STATUS = 2'h0;
  localparam logic [1:0] RFRE_RST_MASK = 2'h0;
  localparam logic [15:0] RFRE_RST_COUNT = 16'h0000;
  // ==========================================================
  // Request carriers
  typedef struct packed {
    logic valid;
    logic root_present;
    logic context_present;
    logic tt_forbids;
    logic pte_rw_any;
    logic pte_rsvd_set;
  } rfre_dma_req_t;
  typedef struct packed {
    logic valid;
    logic remappable;
    logic rsvd_field_set;
    logic [15:0] index;
    logic table_access_err;
    logic entry_present;
    logic entry_rsvd_set;
    logic source_check_fail;
  } rfre_irq_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } rfre_fault_t;
endpackage
`default_nettype wire

/* File: rtl/rfre_dma_sort.sv */
// DMA fault priority encoder
`timescale 1ns/1ps
`default_nettype none
module rfre_dma_sort
  import rfre_pkg::*;
(
  input wire rfre_dma_req_t req,
  output logic hit,
  output logic [7:0] code
);
  // ==========================================================
  // Root first: without it no later entry was ever read
  always_comb begin
    hit = 1'b0;
    code = RFRE_CODE_NONE;
    if (req.valid) begin
      if (!req.root_present) begin
        hit = 1'b1;
        code = RFRE_CODE_ROOT_ABSENT;
      end else if (req.context_present && req.tt_forbids) begin
        hit = 1'b1;
        code = RFRE_CODE_TT_BLOCK;
      end else if (req.pte_rw_any && req.pte_rsvd_set) begin
        hit = 1'b1;
        code = RFRE_CODE_PTE_RSVD;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/rfre_irq_sort.sv */
// Interrupt remapping fault priority encoder
`timescale 1ns/1ps
`default_nettype none
module rfre_irq_sort
  import rfre_pkg::*;
(
  input wire rfre_irq_req_t req,
  input wire logic [15:0] max_index,
  input wire logic extended_irq_mode_enable,
  input wire logic compat_format_allowed_status,
  output logic hit,
  output logic [7:0] code
);
  // ==========================================================
  // Fetch error outranks entry checks: the entry is unusable
  always_comb begin
    hit = 1'b0;
    code = RFRE_CODE_NONE;
    if (req.valid) begin
      hit = 1'b1;
      if (!req.remappable) begin
        if (extended_irq_mode_enable || !compat_format_allowed_status) begin
          code = RFRE_CODE_COMPAT_BLOCK;
        end else begin
          hit = 1'b0;
        end
      end else if (req.rsvd_field_set) begin
        code = RFRE_CODE_IRQ_RSVD;
      end else if (req.index > max_index) begin
        code = RFRE_CODE_IDX_RANGE;
      end else if (req.table_access_err) begin
        code = RFRE_CODE_TABLE_ERR;
      end else if (!req.entry_present) begin
        code = RFRE_CODE_ENTRY_ABSENT;
      end else if (req.entry_rsvd_set) begin
        code = RFRE_CODE_ENTRY_RSVD;
      end else if (req.source_check_fail) begin
        code = RFRE_CODE_SRC_FAIL;
      end else begin
        hit = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/rfre_top.sv */
// Fault reason encoder top: classifiers, fault outputs, APB registers
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rfre_top
  import rfre_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire rfre_dma_req_t DMA_REQ,
  input wire rfre_irq_req_t IRQ_REQ,
  output rfre_fault_t DMA_FAULT,
  output rfre_fault_t IRQ_FAULT,
  output logic [19:0] TABLE_BASE,
  output logic IRQ
);

  // ==========================================================
  // Declarations
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic addr_ok;
  logic acc_end;
  logic wr_ctrl;
  logic wr_tbase;
  logic wr_status;
  logic wr_mask;
  logic compat_format_allowed_status_r;
  logic extended_irq_mode_enable_r;
  logic [3:0] size_r;
  logic [19:0] addr_r;
  logic [1:0] status_r;
  logic [1:0] status_nxt;
  logic [1:0] mask_r;
  logic [7:0] last_dma_r;
  logic [7:0] last_irq_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic irq_r;
  logic [15:0] max_index;
  logic dma_hit;
  logic [7:0] dma_code;
  logic irq_hit;
  logic [7:0] irq_code;
  logic dma_code_ok;
  logic irq_code_ok;
  rfre_fault_t dma_fault_r;
  rfre_fault_t irq_fault_r;
  logic [1:0] event_set;

  // ==========================================================
  // Classifiers
  rfre_dma_sort u_dma_sort (
    .req(DMA_REQ),
    .hit(dma_hit),
    .code(dma_code)
  );

  rfre_irq_sort u_irq_sort (
    .req(IRQ_REQ),
    .max_index(max_index),
    .extended_irq_mode_enable(extended_irq_mode_enable_r),
    .compat_format_allowed_status(compat_format_allowed_status_r),
    .hit(irq_hit),
    .code(irq_code)
  );

  // Table holds 2^(size+1) entries
  assign max_index = 16'hFFFF >> (4'hF - size_r);

  // ==========================================================
  // Code guard: only the codes of its own group leave a channel
  // A classifier slip must never surface as a reserved code
  always_comb begin
    dma_code_ok = 1'b0;
    unique case (dma_code)
      RFRE_CODE_ROOT_ABSENT: begin
        dma_code_ok = 1'b1;
      end
      RFRE_CODE_PTE_RSVD: begin
        dma_code_ok = 1'b1;
      end
      RFRE_CODE_TT_BLOCK: begin
        dma_code_ok = 1'b1;
      end
      default: begin
        dma_code_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    irq_code_ok = 1'b0;
    unique case (irq_code)
      RFRE_CODE_IRQ_RSVD: begin
        irq_code_ok = 1'b1;
      end
      RFRE_CODE_IDX_RANGE: begin
        irq_code_ok = 1'b1;
      end
      RFRE_CODE_ENTRY_ABSENT: begin
        irq_code_ok = 1'b1;
      end
      RFRE_CODE_TABLE_ERR: begin
        irq_code_ok = 1'b1;
      end
      RFRE_CODE_ENTRY_RSVD: begin
        irq_code_ok = 1'b1;
      end
      RFRE_CODE_COMPAT_BLOCK: begin
        irq_code_ok = 1'b1;
      end
      RFRE_CODE_SRC_FAIL: begin
        irq_code_ok = 1'b1;
      end
      default: begin
        irq_code_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Fault outputs, one cycle after the request
  // Separate DMA and interrupt channels so neither is lost
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      dma_fault_r <= '0;
    end else begin
      dma_fault_r.valid <= dma_hit && dma_code_ok;
      dma_fault_r.code <= (dma_hit && dma_code_ok) ? dma_code : RFRE_CODE_NONE;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      irq_fault_r <= '0;
    end else begin
      irq_fault_r.valid <= irq_hit && irq_code_ok;
      irq_fault_r.code <= (irq_hit && irq_code_ok) ? irq_code : RFRE_CODE_NONE;
    end
  end

  assign event_set = {irq_fault_r.valid, dma_fault_r.valid};

  // ==========================================================
  // Last reported codes
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      last_dma_r <= RFRE_CODE_NONE;
    end else if (dma_fault_r.valid) begin
      last_dma_r <= dma_fault_r.code;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      last_irq_r <= RFRE_CODE_NONE;
    end else if (irq_fault_r.valid) begin
      last_irq_r <= irq_fault_r.code;
    end
  end

  // ==========================================================
  // Fault counter, wraps at 16 bits
  always_comb begin
    count_nxt = count_r;
    if (event_set == 2'h3) begin
      count_nxt = count_r + 16'h0002;
    end else if (event_set != 2'h0) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      count_r <= RFRE_RST_COUNT;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ==========================================================
  // APB handshake: one wait state, answer registered
  assign acc_end = PSEL && PENABLE && pready_r;

  always_comb begin
    addr_ok = 1'b0;
    unique case (PADDR)
      RFRE_OFS_CTRL: begin
        addr_ok = 1'b1;
      end
      RFRE_OFS_TBASE: begin
        addr_ok = 1'b1;
      end
      RFRE_OFS_STATUS: begin
        addr_ok = 1'b1;
      end
      RFRE_OFS_MASK: begin
        addr_ok = 1'b1;
      end
      RFRE_OFS_LAST: begin
        addr_ok = 1'b1;
      end
      RFRE_OFS_COUNT: begin
        addr_ok = 1'b1;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= PSEL && PENABLE && !pready_r;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= PSEL && PENABLE && !pready_r && !addr_ok;
    end
  end

  // ==========================================================
  // Write strobes, effective at the edge that samples PREADY
  // Read-only registers ignore writes without error
  assign wr_ctrl = acc_end && PWRITE && (PADDR == RFRE_OFS_CTRL);
  assign wr_tbase = acc_end && PWRITE && (PADDR == RFRE_OFS_TBASE);
  assign wr_status = acc_end && PWRITE && (PADDR == RFRE_OFS_STATUS);
  assign wr_mask = acc_end && PWRITE && (PADDR == RFRE_OFS_MASK);

  // ==========================================================
  // Control and table base
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      compat_format_allowed_status_r <= RFRE_RST_COMPAT_FORMAT_ALLOWED_STATUS;
    end else if (wr_ctrl) begin
      compat_format_allowed_status_r <= PWDATA[RFRE_CTRL_COMPAT_FORMAT_ALLOWED_STATUS_BIT];
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      extended_irq_mode_enable_r <= RFRE_RST_EXTENDED_IRQ_MODE_ENABLE;
      size_r <= RFRE_RST_SIZE;
      addr_r <= RFRE_RST_ADDR;
    end else if (wr_tbase) begin
      extended_irq_mode_enable_r <= PWDATA[RFRE_TBASE_EXTENDED_IRQ_MODE_ENABLE_BIT];
      size_r <= PWDATA[RFRE_TBASE_SIZE_LSB +: 4];
      addr_r <= PWDATA[RFRE_TBASE_ADDR_LSB +: 20];
    end
  end

  // ==========================================================
  // Sticky status, write one to clear; a new event wins
  always_comb begin
    status_nxt = status_r;
    if (wr_status) begin
      status_nxt = status_r & ~PWDATA[1:0];
    end
    status_nxt = status_nxt | event_set;
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      status_r <= RFRE_RST_STATUS;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      mask_r <= RFRE_RST_MASK;
    end else if (wr_mask) begin
      mask_r <= PWDATA[1:0];
    end
  end

  // Level interrupt, updated on the same edge as status
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & mask_r);
    end
  end

  // ==========================================================
  // Read data, captured in the wait cycle
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    unique case (PADDR)
      RFRE_OFS_CTRL: begin
        prdata_nxt[RFRE_CTRL_COMPAT_FORMAT_ALLOWED_STATUS_BIT] = compat_format_allowed_status_r;
      end
      RFRE_OFS_TBASE: begin
        prdata_nxt[RFRE_TBASE_SIZE_LSB +: 4] = size_r;
        prdata_nxt[RFRE_TBASE_EXTENDED_IRQ_MODE_ENABLE_BIT] = extended_irq_mode_enable_r;
        prdata_nxt[RFRE_TBASE_ADDR_LSB +: 20] = addr_r;
      end
      RFRE_OFS_STATUS: begin
        prdata_nxt[RFRE_ST_DMA_BIT] = status_r[0];
        prdata_nxt[RFRE_ST_IRQ_BIT] = status_r[1];
      end
      RFRE_OFS_MASK: begin
        prdata_nxt[1:0] = mask_r;
      end
      RFRE_OFS_LAST: begin
        prdata_nxt[RFRE_LAST_DMA_LSB +: 8] = last_dma_r;
        prdata_nxt[RFRE_LAST_IRQ_LSB +: 8] = last_irq_r;
      end
      RFRE_OFS_COUNT: begin
        prdata_nxt[15:0] = count_r;
      end
      default: begin
        prdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      prdata_r <= 32'h0000_0000;
    end else if (PSEL && PENABLE && !pready_r && !PWRITE) begin
      prdata_r <= prdata_nxt;
    end else begin
      prdata_r <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Outputs
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign DMA_FAULT = dma_fault_r;
  assign IRQ_FAULT = irq_fault_r;
  assign TABLE_BASE = addr_r;
  assign IRQ = irq_r;

endmodule
`default_nettype wire

/* File: verif/rfre_checker.sv */
// Checker: fault code encoding and priority properties
`timescale 1ns/1ps
`default_nettype none
module rfre_checker
  import rfre_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire rfre_dma_req_t DMA_REQ,
  input wire rfre_irq_req_t IRQ_REQ,
  input wire rfre_fault_t DMA_FAULT,
  input wire rfre_fault_t IRQ_FAULT
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  // ==========================================================
  // Helpers
  // Index 1 is in range for every table size
  logic irq_ok;
  logic dma_ok;
  assign irq_ok = IRQ_REQ.valid && IRQ_REQ.remappable && !IRQ_REQ.rsvd_field_set && IRQ_REQ.index <= 16'h0001;
  assign dma_ok = DMA_REQ.valid && DMA_REQ.root_present;
  // ==========================================================
  // Properties
  property p_dma_codes;
    DMA_FAULT.valid |-> DMA_FAULT.code inside {8'h01, 8'h0C, 8'h0D};
  endproperty
  a_dma_codes: assert property (p_dma_codes) else $error("dma code out of set");
  property p_irq_codes;
    IRQ_FAULT.valid |-> IRQ_FAULT.code inside {[8'h20:8'h26]};
  endproperty
  a_irq_codes: assert property (p_irq_codes) else $error("irq code out of set");
  property p_root;
    DMA_REQ.valid && !DMA_REQ.root_present |=> DMA_FAULT.valid && DMA_FAULT.code == 8'h01;
  endproperty
  a_root: assert property (p_root) else $error("root absent code wrong");
  property p_tt;
    dma_ok && DMA_REQ.context_present && DMA_REQ.tt_forbids |=> DMA_FAULT.valid && DMA_FAULT.code == 8'h0D;
  endproperty
  a_tt: assert property (p_tt) else $error("type block code wrong");
  property p_pte;
    dma_ok && !(DMA_REQ.context_present && DMA_REQ.tt_forbids) && DMA_REQ.pte_rw_any && DMA_REQ.pte_rsvd_set
      |=> DMA_FAULT.valid && DMA_FAULT.code == 8'h0C;
  endproperty
  a_pte: assert property (p_pte) else $error("page entry code wrong");
  property p_irq_rsvd;
    IRQ_REQ.valid && IRQ_REQ.remappable && IRQ_REQ.rsvd_field_set |=> IRQ_FAULT.valid && IRQ_FAULT.code == 8'h20;
  endproperty
  a_irq_rsvd: assert property (p_irq_rsvd) else $error("request reserved code wrong");
  property p_tbl_err;
    irq_ok && IRQ_REQ.table_access_err |=> IRQ_FAULT.valid && IRQ_FAULT.code == 8'h23;
  endproperty
  a_tbl_err: assert property (p_tbl_err) else $error("table error code wrong");
  property p_absent;
    irq_ok && !IRQ_REQ.table_access_err && !IRQ_REQ.entry_present |=> IRQ_FAULT.valid && IRQ_FAULT.code == 8'h22;
  endproperty
  a_absent: assert property (p_absent) else $error("absent entry code wrong");
  property p_src;
    irq_ok && !IRQ_REQ.table_access_err && IRQ_REQ.entry_present && !IRQ_REQ.entry_rsvd_set
      && IRQ_REQ.source_check_fail |=> IRQ_FAULT.valid && IRQ_FAULT.code == 8'h26;
  endproperty
  a_src: assert property (p_src) else $error("source check code wrong");
  property p_entry_rsvd;
    irq_ok && !IRQ_REQ.table_access_err && IRQ_REQ.entry_present && IRQ_REQ.entry_rsvd_set
      |=> IRQ_FAULT.valid && IRQ_FAULT.code == 8'h24;
  endproperty
  a_entry_rsvd: assert property (p_entry_rsvd) else $error("entry reserved code wrong");
  property p_compat;
    IRQ_REQ.valid && !IRQ_REQ.remappable |=> !IRQ_FAULT.valid || IRQ_FAULT.code == 8'h25;
  endproperty
  a_compat: assert property (p_compat) else $error("compat block code wrong");
  property p_no_zero;
    DMA_FAULT.valid || IRQ_FAULT.valid
      |-> (!DMA_FAULT.valid || DMA_FAULT.code != 8'h00) && (!IRQ_FAULT.valid || IRQ_FAULT.code != 8'h00);
  endproperty
  a_no_zero: assert property (p_no_zero) else $error("zero reported as fault");
  property p_dma_cause;
    DMA_FAULT.valid |-> $past(DMA_REQ.valid);
  endproperty
  a_dma_cause: assert property (p_dma_cause) else $error("dma fault without request");
  property p_irq_cause;
    IRQ_FAULT.valid |-> $past(IRQ_REQ.valid);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq fault without request");
endmodule
bind rfre_top rfre_checker u_chk (
  .CLOCK(CLOCK),
  .RSTN(RSTN),
  .DMA_REQ(DMA_REQ),
  .IRQ_REQ(IRQ_REQ),
  .DMA_FAULT(DMA_FAULT),
  .IRQ_FAULT(IRQ_FAULT)
);
`default_nettype wire

/* File: verif/rfre_dev_model.sv */
// Device model: issues one DMA or interrupt request per go pulse, or both at once for kind F
`timescale 1ns/1ps
`default_nettype none
module rfre_dev_model
  import rfre_pkg::*;
(
  input wire logic clock,
  input wire logic go,
  input wire logic [3:0] kind,
  output var rfre_dma_req_t dma_req,
  output var rfre_irq_req_t irq_req
);
  function automatic rfre_irq_req_t mk(input logic rm, rs, input logic [15:0] idx, input logic er, pr, ers, sf);
    mk = '{1'b1, rm, rs, idx, er, pr, ers, sf};
  endfunction
  initial begin
    dma_req = '0;
    irq_req = '0;
  end
  rfre_dma_req_t dma_nxt;
  rfre_irq_req_t irq_nxt;
  // Idle fields toggle so stale values never pass as meaningful
  // One update per edge, so a request never changes twice in a step
  always @(posedge clock) begin
    dma_nxt = {1'b0, ~dma_req[4:0]};
    irq_nxt = {1'b0, ~irq_req[21:0]};
    if (go) begin
      case (kind)
        4'h0: dma_nxt = 6'h20;
        4'h1: dma_nxt = 6'h3C;
        4'h2: dma_nxt = 6'h33;
        4'h3: dma_nxt = 6'h2F;
        4'h4: irq_nxt = mk(1'b0, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0);
        4'h5: irq_nxt = mk(1'b1, 1'b1, 16'hFFFF, 1'b1, 1'b0, 1'b1, 1'b1);
        4'h6: irq_nxt = mk(1'b1, 1'b0, 16'h0002, 1'b1, 1'b1, 1'b1, 1'b1);
        4'h7: irq_nxt = mk(1'b1, 1'b0, 16'h0001, 1'b1, 1'b0, 1'b1, 1'b1);
        4'h8: irq_nxt = mk(1'b1, 1'b0, 16'h0001, 1'b0, 1'b0, 1'b1, 1'b1);
        4'h9: irq_nxt = mk(1'b1, 1'b0, 16'h0001, 1'b0, 1'b1, 1'b1, 1'b1);
        4'hA: irq_nxt = mk(1'b1, 1'b0, 16'h0001, 1'b0, 1'b1, 1'b0, 1'b1);
        // Both channels fault in one cycle
        4'hF: begin
          dma_nxt = 6'h20;
          irq_nxt = mk(1'b1, 1'b0, 16'h0001, 1'b0, 1'b0, 1'b0, 1'b0);
        end
        default: irq_nxt = mk(1'b1, 1'b0, 16'h0001, 1'b0, 1'b1, 1'b0, 1'b0);
      endcase
    end
    dma_req <= dma_nxt;
    irq_req <= irq_nxt;
  end
endmodule
`default_nettype wire

/* File: verif/test_remap_fault_reason_encoder.sv */
// Testbench: APB register access and fault code scenarios
`timescale 1ns/1ps
`default_nettype none
module test_remap_fault_reason_encoder import rfre_pkg::*;;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, pready, pslverr, irq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] kind = 4'h0;
  logic [19:0] table_base;
  rfre_dma_req_t dma_req;
  rfre_irq_req_t irq_req;
  rfre_fault_t dma_fault, irq_fault;
  int err_count = 0, checks_done = 0, cycles = 0;
  logic [7:0] exp_code [12] = '{8'h01, 8'h0D, 8'h0C, 8'h01, 8'h25, 8'h20, 8'h21, 8'h23, 8'h22, 8'h24, 8'h26, 8'h00};
  always #25 clock = ~clock;
  rfre_top DUT (.CLOCK(clock), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DMA_REQ(dma_req), .IRQ_REQ(irq_req),
    .DMA_FAULT(dma_fault), .IRQ_FAULT(irq_fault), .TABLE_BASE(table_base), .IRQ(irq));
  rfre_dev_model u_dev (.clock(clock), .go(go), .kind(kind), .dma_req(dma_req), .irq_req(irq_req));
  // ==========================================================
  // Tasks
  task automatic final_report();
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // No fixed latency assumed; PREADY high or the timeout ends this wait
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic e;
    apb(1'b0, a, 32'h0000_0000, e);
    chk(rd, exp);
    chk({31'h0000_0000, e}, {31'h0000_0000, experr});
  endtask
  task automatic fire(input logic [3:0] k, input logic [7:0] exp);
    @(posedge clock);
    go <= 1'b1;
    kind <= k;
    @(posedge clock);
    go <= 1'b0;
    repeat (2) @(negedge clock);
    chk(k < 4'h4 ? dma_fault : irq_fault, {23'h00_0000, exp != 8'h00, exp});
  endtask
  task automatic irq_chk(input logic exp);
    repeat (2) @(negedge clock);
    chk({31'h0000_0000, irq}, {31'h0000_0000, exp});
  endtask
  // ==========================================================
  // Timeout
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      final_report();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    rchk(RFRE_OFS_CTRL, 32'h0000_0000, 1'b0);
    rchk(RFRE_OFS_TBASE, 32'h0000_0000, 1'b0);
    for (int k = 0; k < 12; k++) fire(k[3:0], exp_code[k]);
    rchk(RFRE_OFS_STATUS, 32'h0000_0003, 1'b0);
    rchk(RFRE_OFS_LAST, 32'h0000_2601, 1'b0);
    rchk(RFRE_OFS_COUNT, 32'h0000_000B, 1'b0);
    wr(RFRE_OFS_LAST, 32'hFFFF_FFFF);
    rchk(RFRE_OFS_LAST, 32'h0000_2601, 1'b0);
    wr(RFRE_OFS_MASK, 32'h0000_0002);
    irq_chk(1'b1);
    wr(RFRE_OFS_STATUS, 32'h0000_0002);
    irq_chk(1'b0);
    rchk(RFRE_OFS_STATUS, 32'h0000_0001, 1'b0);
    wr(RFRE_OFS_CTRL, 32'h0000_0001);
    fire(4'h4, 8'h00);
    wr(RFRE_OFS_TBASE, 32'hABCD_E800);
    rchk(RFRE_OFS_TBASE, 32'hABCD_E800, 1'b0);
    chk({12'h000, table_base}, 32'h000A_BCDE);
    fire(4'h4, 8'h25);
    wr(RFRE_OFS_TBASE, 32'hABCD_E001);
    fire(4'h6, 8'h23);
    fire(4'hF, 8'h22);
    rchk(RFRE_OFS_COUNT, 32'h0000_000F, 1'b0);
    rchk(RFRE_OFS_LAST, 32'h0000_2201, 1'b0);
    rchk(8'h20, 32'h0000_0000, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
